// *** src/pft_pwm_fault_trigger.sv ***
/*
 * PWM fault override, trigger compare and edge blanking,
 * with an APB register slave and a masked interrupt.
 * Assumes PWM core inputs on pclk;
 * fault and limit sources are asynchronous.
 */
`timescale 1ns/100ps

module pft_pwm_fault_trigger
    import pft_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              pwm_high_in,
    input  wire logic              pwm_low_in,
    input  wire logic [15:0]       pwm_time_base,
    input  wire logic              period_start,
    input  wire logic [3:0]        comparator_in,
    input  wire logic [3:0]        shared_fault_in,
    input  wire logic              independent_fault_two,
    input  wire logic              independent_fault_four,
    input  wire logic              limit_in,
    output logic                   high_side_output,
    output logic                   low_side_output,
    output logic                   limit_active,
    output logic                   adc_trigger,
    output logic                   irq
);

    typedef struct packed {
        logic [15:0] fault_limit_control;
        logic [15:0] trigger_compare_value;
        logic [15:0] edge_blank_control;
        logic [1:0]  fault_override_values;
        logic [2:0]  int_status;
        logic [2:0]  int_mask;
        logic [10:0] sync_a;
        logic [10:0] sync_b;
        logic        fault_latched;
        logic        fault_cycle;
        logic [7:0]  blank_cnt;
        logic        high_prev;
        logic        low_prev;
        logic        match_prev;
        logic        high_out;
        logic        low_out;
        logic        limit_out;
        logic        adc_trig;
        logic        irq_out;
        logic        pready_out;
        logic        pslverr_out;
        logic [31:0] prdata_out;
    } pft_state_t;

    pft_state_t state_r;
    pft_state_t state_nxt;

    logic        fault_sel;
    logic [1:0]  mode;
    logic        blanking;
    logic        high_rise;
    logic        high_fall;
    logic        low_rise;
    logic        low_fall;
    logic        retrigger;
    logic        fault_eff;
    logic        latch_set;
    logic        cycle_set;
    logic        override;
    logic        match;
    logic        setup_ph;
    logic        access_wr;
    logic [31:0] read_word;
    logic        addr_ok;
    logic [2:0]  events;

    // Blanking time in whole pclk cycles, rounded up so it never falls short
    function automatic logic [7:0] blank_cycles(input logic [6:0] steps);
        logic [15:0] ns;
        logic [15:0] cyc;
        ns  = {9'h000, steps} * PFT_BLANK_STEP_NS;
        cyc = (ns + PFT_CLK_PERIOD_NS - 16'd1) / PFT_CLK_PERIOD_NS;
        return cyc[7:0];
    endfunction : blank_cycles

    // True when a byte address names one of our registers
    function automatic logic addr_hit(input logic [11:0] a);
        return (a == PFT_OFF_FAULT_LIMIT) || (a == PFT_OFF_TRIGGER) ||
               (a == PFT_OFF_BLANK) || (a == PFT_OFF_OVERRIDE) ||
               (a == PFT_OFF_INT_STATUS) || (a == PFT_OFF_INT_MASK) ||
               (a == PFT_OFF_FAULT_STATE);
    endfunction : addr_hit

    // Source select reads only the second synchroniser stage
    pft_fault_select u_fault_select (
        .source_select          (state_r.fault_limit_control[PFT_FLC_SRC_LSB +: 4]),
        .fault_polarity         (state_r.fault_limit_control[PFT_FLC_POL_BIT]),
        .comparator_in          (state_r.sync_b[3:0]),
        .shared_fault_in        (state_r.sync_b[7:4]),
        .independent_fault_two  (state_r.sync_b[8]),
        .independent_fault_four (state_r.sync_b[9]),
        .fault_active           (fault_sel)
    );

    // Register read mux; unimplemented bits come back as zero
    always_comb begin
        read_word = 32'h0000_0000;
        case (paddr[11:0])
            PFT_OFF_FAULT_LIMIT: read_word[15:0] = state_r.fault_limit_control;
            PFT_OFF_TRIGGER:     read_word[15:0] = state_r.trigger_compare_value;
            PFT_OFF_BLANK:       read_word[15:0] = state_r.edge_blank_control;
            PFT_OFF_OVERRIDE:    read_word[1:0]  = state_r.fault_override_values;
            PFT_OFF_INT_STATUS:  read_word[2:0]  = state_r.int_status;
            PFT_OFF_INT_MASK:    read_word[2:0]  = state_r.int_mask;
            PFT_OFF_FAULT_STATE: read_word[3:0]  = {fault_eff, blanking,
                                                    state_r.fault_cycle,
                                                    state_r.fault_latched};
            default:             read_word = 32'h0000_0000;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        state_nxt = state_r;
        addr_ok   = addr_hit(paddr[11:0]);
        setup_ph  = psel & ~penable;
        access_wr = psel & penable & state_r.pready_out & pwrite & ~state_r.pslverr_out;
        mode      = state_r.fault_limit_control[PFT_FLC_MODE_LSB +: 2];

        // Two-flop synchronisers for all asynchronous fault and limit inputs
        state_nxt.sync_a = {limit_in, independent_fault_four, independent_fault_two,
                            shared_fault_in, comparator_in};
        state_nxt.sync_b = state_r.sync_a;

        // Output edge detection feeds the blanking restart
        high_rise = pwm_high_in & ~state_r.high_prev;
        high_fall = ~pwm_high_in & state_r.high_prev;
        low_rise  = pwm_low_in & ~state_r.low_prev;
        low_fall  = ~pwm_low_in & state_r.low_prev;
        state_nxt.high_prev = pwm_high_in;
        state_nxt.low_prev  = pwm_low_in;
        retrigger = (state_r.edge_blank_control[PFT_BLK_HR_BIT] & high_rise) |
                    (state_r.edge_blank_control[PFT_BLK_HF_BIT] & high_fall) |
                    (state_r.edge_blank_control[PFT_BLK_LR_BIT] & low_rise) |
                    (state_r.edge_blank_control[PFT_BLK_LF_BIT] & low_fall);

        // Blanking counter: reload on an enabled edge, else count down to zero
        blanking = (state_r.blank_cnt != 8'h00);
        if (retrigger) begin
            state_nxt.blank_cnt = blank_cycles(state_r.edge_blank_control[9:3]);
        end else if (blanking) begin
            state_nxt.blank_cnt = state_r.blank_cnt - 8'h01;
        end

        // Blanked inputs look inactive only while their enable is set
        fault_eff = fault_sel & ~(state_r.edge_blank_control[PFT_BLK_FEN_BIT] & blanking);
        state_nxt.limit_out = state_r.sync_b[10] &
                              ~(state_r.edge_blank_control[PFT_BLK_LEN_BIT] & blanking);

        latch_set = (mode == PFT_MODE_LATCH) & fault_eff;
        cycle_set = (mode == PFT_MODE_CYCLE) & fault_eff;

        // Cycle override drops at period start; a fault in that cycle re-arms it
        if (period_start) begin
            state_nxt.fault_cycle = 1'b0;
        end
        if (cycle_set) begin
            state_nxt.fault_cycle = 1'b1;
        end

        // Latch clears by software only; a still-active fault wins over the clear
        if (access_wr && paddr[11:0] == PFT_OFF_FAULT_STATE && pwdata[PFT_FST_LATCH]) begin
            state_nxt.fault_latched = 1'b0;
        end
        if (latch_set) begin
            state_nxt.fault_latched = 1'b1;
        end

        // Disabled or reserved mode drops any override in force
        if (mode == PFT_MODE_OFF || mode == PFT_MODE_RESERVED) begin
            state_nxt.fault_latched = 1'b0;
            state_nxt.fault_cycle   = 1'b0;
        end

        // Override values replace both PWM outputs while a fault holds
        override = state_nxt.fault_latched | state_nxt.fault_cycle;
        state_nxt.high_out = override ? state_r.fault_override_values[1] : pwm_high_in;
        state_nxt.low_out  = override ? state_r.fault_override_values[0] : pwm_low_in;

        // Trigger compare; zero never matches, one pulse per match entry
        match = (state_r.trigger_compare_value != 16'h0000) &&
                (pwm_time_base == state_r.trigger_compare_value);
        state_nxt.match_prev = match;
        state_nxt.adc_trig   = match & ~state_r.match_prev;

        // Sticky events, cleared by writing one, set wins over clear
        events = 3'h0;
        events[PFT_INT_TRIG]  = match & ~state_r.match_prev;
        events[PFT_INT_LATCH] = latch_set & ~state_r.fault_latched;
        events[PFT_INT_CYCLE] = cycle_set & ~state_r.fault_cycle;
        if (access_wr && paddr[11:0] == PFT_OFF_INT_STATUS) begin
            state_nxt.int_status = state_r.int_status & ~pwdata[2:0];
        end
        state_nxt.int_status = state_nxt.int_status | events;

        // Register writes at the access edge, implemented bits only
        if (access_wr) begin
            case (paddr[11:0])
                PFT_OFF_FAULT_LIMIT:
                    state_nxt.fault_limit_control = pwdata[15:0] & PFT_MASK_FAULT_LIMIT;
                PFT_OFF_TRIGGER:
                    state_nxt.trigger_compare_value = pwdata[15:0] & PFT_MASK_TRIGGER;
                PFT_OFF_BLANK:
                    state_nxt.edge_blank_control = pwdata[15:0] & PFT_MASK_BLANK;
                PFT_OFF_OVERRIDE:
                    state_nxt.fault_override_values = pwdata[1:0];
                PFT_OFF_INT_MASK:
                    state_nxt.int_mask = pwdata[2:0];
                default: begin
                end
            endcase
        end

        // Level interrupt registered from the next status and mask, so it rises with the status bit
        state_nxt.irq_out = |(state_nxt.int_status & state_nxt.int_mask);

        // One-cycle access phase: answer is prepared during setup
        if (setup_ph) begin
            state_nxt.pready_out  = 1'b1;
            state_nxt.pslverr_out = ~addr_ok;
            state_nxt.prdata_out  = pwrite ? 32'h0000_0000 : read_word;
        end else begin
            state_nxt.pready_out  = 1'b0;
            state_nxt.pslverr_out = 1'b0;
        end
    end

    // Single state register; everything clears to zero at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
            state_r.fault_limit_control   <= PFT_RST_FAULT_LIMIT;
            state_r.trigger_compare_value <= PFT_RST_TRIGGER;
            state_r.edge_blank_control    <= PFT_RST_BLANK;
            state_r.fault_override_values <= PFT_RST_OVERRIDE;
            state_r.int_status            <= PFT_RST_INT;
            state_r.int_mask              <= PFT_RST_INT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state flops
    assign prdata           = state_r.prdata_out;
    assign pready           = state_r.pready_out;
    assign pslverr          = state_r.pslverr_out;
    assign high_side_output = state_r.high_out;
    assign low_side_output  = state_r.low_out;
    assign limit_active     = state_r.limit_out;
    assign adc_trigger      = state_r.adc_trig;
    assign irq              = state_r.irq_out;

endmodule : pft_pwm_fault_trigger

// *** src/pft_pkg.sv ***
/*
 * Offsets, fields, reset values, masks and timing of the fault block.
 * Assumes a 32-bit APB bus and a 10 MHz pclk.
 */
package pft_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [11:0] PFT_OFF_FAULT_LIMIT  = 12'h000;
    localparam logic [11:0] PFT_OFF_TRIGGER      = 12'h004;
    localparam logic [11:0] PFT_OFF_BLANK        = 12'h008;
    localparam logic [11:0] PFT_OFF_OVERRIDE     = 12'h00C;
    localparam logic [11:0] PFT_OFF_INT_STATUS   = 12'h010;
    localparam logic [11:0] PFT_OFF_INT_MASK     = 12'h014;
    localparam logic [11:0] PFT_OFF_FAULT_STATE  = 12'h018;

    // Values after reset
    localparam logic [15:0] PFT_RST_FAULT_LIMIT  = 16'h0000;
    localparam logic [15:0] PFT_RST_TRIGGER      = 16'h0000;
    localparam logic [15:0] PFT_RST_BLANK        = 16'h0000;
    localparam logic [1:0]  PFT_RST_OVERRIDE     = 2'h0;
    localparam logic [2:0]  PFT_RST_INT          = 3'h0;

    // Implemented bits of each register
    localparam logic [15:0] PFT_MASK_FAULT_LIMIT = 16'h1FFF;
    localparam logic [15:0] PFT_MASK_TRIGGER     = 16'hFFF8;
    localparam logic [15:0] PFT_MASK_BLANK       = 16'hFFF8;

    // Fault/limit control fields
    localparam int PFT_FLC_MODE_LSB = 0;
    localparam int PFT_FLC_POL_BIT  = 2;
    localparam int PFT_FLC_SRC_LSB  = 3;

    // Fault mode encodings
    localparam logic [1:0] PFT_MODE_LATCH    = 2'h0;
    localparam logic [1:0] PFT_MODE_CYCLE    = 2'h1;
    localparam logic [1:0] PFT_MODE_RESERVED = 2'h2;
    localparam logic [1:0] PFT_MODE_OFF      = 2'h3;

    // Blanking control fields
    localparam int PFT_BLK_HR_BIT   = 15;
    localparam int PFT_BLK_HF_BIT   = 14;
    localparam int PFT_BLK_LR_BIT   = 13;
    localparam int PFT_BLK_LF_BIT   = 12;
    localparam int PFT_BLK_FEN_BIT  = 11;
    localparam int PFT_BLK_LEN_BIT  = 10;
    localparam int PFT_BLK_DUR_LSB  = 3;

    // Interrupt status bit positions
    localparam int PFT_INT_TRIG     = 0;
    localparam int PFT_INT_LATCH    = 1;
    localparam int PFT_INT_CYCLE    = 2;

    // Fault state register: write one to bit 0 clears the latch
    localparam int PFT_FST_LATCH    = 0;

    // Timing
    localparam logic [15:0] PFT_CLK_PERIOD_NS = 16'd100;
    localparam logic [15:0] PFT_BLANK_STEP_NS = 16'd8;

endpackage : pft_pkg

// *** src/pft_fault_select.sv ***
/*
 * Fault source multiplexer with programmable polarity.
 * Assumes every source input has already been synchronised to pclk.
 */
`timescale 1ns/100ps

module pft_fault_select
    import pft_pkg::*;
(
    input  wire logic [3:0] source_select,
    input  wire logic       fault_polarity,
    input  wire logic [3:0] comparator_in,
    input  wire logic [3:0] shared_fault_in,
    input  wire logic       independent_fault_two,
    input  wire logic       independent_fault_four,
    output logic            fault_active
);

    logic picked;
    logic valid;

    // Source decode; reserved codes select nothing
    always_comb begin
        picked = 1'b0;
        valid  = 1'b1;
        case (source_select)
            4'h0, 4'h1, 4'h2, 4'h3: picked = comparator_in[source_select[1:0]];
            4'h8, 4'h9, 4'hA, 4'hB: picked = shared_fault_in[source_select[1:0]];
            4'hD:                   picked = independent_fault_two;
            4'hF:                   picked = independent_fault_four;
            default:                valid  = 1'b0;
        endcase
    end

    // A reserved code never faults, whatever the polarity
    assign fault_active = valid & (picked ^ fault_polarity);

endmodule : pft_fault_select

// *** bench/pft_properties.sv ***
/* Checker: APB answers, register reads, trigger, override hold, blanking.
   Assumes binding to the design on one clock. */
`timescale 1ns/100ps
module pft_properties
    import pft_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              pwm_high_in,
    input wire logic              pwm_low_in,
    input wire logic [15:0]       pwm_time_base,
    input wire logic              period_start,
    input wire logic              limit_in,
    input wire logic              high_side_output,
    input wire logic              low_side_output,
    input wire logic              limit_active,
    input wire logic              adc_trigger
);
    logic [15:0] trig_r, blk_r, flc_r;
    logic [1:0]  ovr_r;
    wire         wr_ok = psel && penable && pwrite && pready;
    wire         rd_ok = psel && penable && !pwrite && pready;
    wire  [15:0] trig_v = trig_r & PFT_MASK_TRIGGER;
    wire  [1:0]  hl = {high_side_output, low_side_output};
    // Mirror of written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_r <= 16'h0000;
            blk_r  <= 16'h0000;
            flc_r  <= 16'h0000;
            ovr_r  <= 2'h0;
        end else if (wr_ok && !pslverr) begin
            if (paddr == PFT_OFF_TRIGGER) trig_r <= pwdata[15:0];
            if (paddr == PFT_OFF_BLANK) blk_r <= pwdata[15:0];
            if (paddr == PFT_OFF_FAULT_LIMIT) flc_r <= pwdata[15:0];
            if (paddr == PFT_OFF_OVERRIDE) ovr_r <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // Override shown, no register write close enough to move it
    sequence s_held(logic [1:0] m);
        flc_r[1:0] == m && !wr_ok && !$past(wr_ok) && !$past(wr_ok, 2) && $past(presetn)
        && hl == ovr_r && hl != {$past(pwm_high_in), $past(pwm_low_in)};
    endsequence
    a_setup_ready: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_err_zero: assert property (rd_ok && pslverr |-> prdata == 32'h0) else $error("err read");
    a_trig_read: assert property (
        rd_ok && paddr == PFT_OFF_TRIGGER |-> prdata == {16'h0, trig_v}) else $error("trig read");
    a_blank_read: assert property (
        rd_ok && paddr == PFT_OFF_BLANK |-> prdata == {16'h0, blk_r & PFT_MASK_BLANK})
        else $error("blank read");
    a_trig_match: assert property (
        adc_trigger |-> $past(pwm_time_base) == $past(trig_v) && $past(trig_v) != 16'h0)
        else $error("trigger without match");
    a_latch_hold: assert property (
        s_held(PFT_MODE_LATCH) |=> hl == ovr_r) else $error("latched override lost");
    a_cycle_hold: assert property (
        s_held(PFT_MODE_CYCLE) ##0 !period_start && !$past(period_start)
        && !$past(period_start, 2) |=> hl == ovr_r) else $error("cycle override lost");
    a_mode_off: assert property (
        flc_r[1] [*3] |-> high_side_output == $past(pwm_high_in)
        && low_side_output == $past(pwm_low_in)) else $error("override while disabled");
    a_limit_pass: assert property (
        (!blk_r[PFT_BLK_LEN_BIT] && $stable(limit_in)) [*5] |-> limit_active == limit_in)
        else $error("limit blanked while disabled");
endmodule : pft_properties

bind pft_pwm_fault_trigger pft_properties #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_high_in,
    .pwm_low_in, .pwm_time_base, .period_start, .limit_in, .high_side_output,
    .low_side_output, .limit_active, .adc_trigger);

// *** bench/pft_far_model.sv ***
/* Far side: PWM core time base with complementary outputs, fault and
   limit sources as commanded, and a count of ADC trigger pulses. */
`timescale 1ns/100ps
module pft_far_model
#(
    parameter int PER  = 32,
    parameter int DUTY = 12
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [10:0] src,
    input  wire logic        adc_trigger,
    output logic             pwm_high_in,
    output logic             pwm_low_in,
    output logic      [15:0] pwm_time_base,
    output logic             period_start,
    output logic      [3:0]  comparator_in,
    output logic      [3:0]  shared_fault_in,
    output logic             independent_fault_two,
    output logic             independent_fault_four,
    output logic             limit_in,
    output int               trig_cnt
);
    // Time base wraps every PER cycles; trigger pulses are tallied
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_time_base <= 16'h0000;
            trig_cnt      <= 0;
        end else begin
            pwm_time_base <= (pwm_time_base == 16'(PER - 1)) ? 16'h0000 : pwm_time_base + 16'h1;
            trig_cnt      <= trig_cnt + int'(adc_trigger);
        end
    end
    // Complementary pair, so both high can only be an override
    assign period_start = (pwm_time_base == 16'h0000);
    assign pwm_high_in  = (pwm_time_base < 16'(DUTY));
    assign pwm_low_in   = !pwm_high_in;
    // Sources follow the bench directly, no memory of old levels
    assign {limit_in, independent_fault_four, independent_fault_two,
            shared_fault_in, comparator_in} = src;
endmodule : pft_far_model

// *** bench/test_pft_pwm_fault_trigger.sv ***
/* Bench: registers, fault routing, modes, trigger and blanking.
   Assumes pft_far_model as the far side. */
`timescale 1ns/100ps
module test_pft_pwm_fault_trigger
    import pft_pkg::*;
;
    localparam int PER = 32;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        pwm_high_in, pwm_low_in, period_start, limit_in, adc_trigger, irq;
    logic        independent_fault_two, independent_fault_four, limit_active;
    logic        high_side_output, low_side_output;
    wire  [1:0]  hl = {high_side_output, low_side_output};
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] pwm_time_base;
    logic [10:0] src;
    logic [3:0]  comparator_in, shared_fault_in;
    logic        e;
    int          error_cnt, n_checks, cyc, tc, trig_cnt;

    pft_pwm_fault_trigger DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pwm_high_in, .pwm_low_in, .pwm_time_base, .period_start,
        .comparator_in, .shared_fault_in, .independent_fault_two, .independent_fault_four,
        .limit_in, .high_side_output, .low_side_output, .limit_active, .adc_trigger, .irq);
    pft_far_model #(.PER(PER)) u_far (.pclk, .presetn, .src, .adc_trigger, .pwm_high_in,
        .pwm_low_in, .pwm_time_base, .period_start, .comparator_in, .shared_fault_in,
        .independent_fault_two, .independent_fault_four, .limit_in, .trig_cnt);

    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n
    // One transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
        apb(1'b0, a, 32'h0);
        chk(q, x, m);
    endtask : rd
    function automatic int src_of(input int c);
        if (c < 4) return c;
        if (c >= 8 && c < 12) return c - 4;
        if (c == 13) return 8;
        if (c == 15) return 9;
        return -1;
    endfunction : src_of

    task automatic t_regs();
        rd(PFT_OFF_TRIGGER, 32'h0, "trig reset");
        rd(PFT_OFF_BLANK, 32'h0, "blank reset");
        wr(PFT_OFF_TRIGGER, 32'hFFFFFFFF);
        rd(PFT_OFF_TRIGGER, 32'h0000FFF8, "trig bits");
        wr(PFT_OFF_BLANK, 32'h0000FFFF);
        rd(PFT_OFF_BLANK, 32'h0000FFF8, "blank bits");
        wr(PFT_OFF_BLANK, 32'h0);
        wr(PFT_OFF_TRIGGER, 32'h0);
        rd(12'h0FC, 32'h0, "unmapped read");
        chk(e, 1'b1, "unmapped error");
        $display("t_regs done");
    endtask : t_regs
    // Every source code: others active first, then only the routed one
    task automatic t_src();
        int k;
        wr(PFT_OFF_OVERRIDE, 32'h3);
        for (int c = 0; c < 16; c++) begin
            k = src_of(c);
            wr(PFT_OFF_FAULT_LIMIT, 32'(c * 8 + 1));
            src <= (k < 0) ? 11'h3FF : 11'h3FF ^ (11'h1 << k);
            wait_n(8);
            chk(^hl, 1'b1, "no fault");
            if (k >= 0) begin
                src <= 11'h1 << k;
                wait_n(8);
                chk(hl, 2'h3, "override");
            end
            src <= 11'h0;
            wait_n(PER + 8);
            chk(^hl, 1'b1, "released");
        end
        wr(PFT_OFF_FAULT_LIMIT, 32'h5);
        wait_n(8);
        chk(hl, 2'h3, "low active");
        src <= 11'h1;
        wait_n(PER + 8);
        chk(^hl, 1'b1, "low idle");
        $display("t_src done");
    endtask : t_src
    task automatic t_modes();
        wr(PFT_OFF_INT_STATUS, 32'h7);
        wr(PFT_OFF_INT_MASK, 32'h0);
        wr(PFT_OFF_FAULT_LIMIT, 32'h40);
        src <= 11'h10;
        wait_n(4);
        src <= 11'h0;
        wait_n(PER + 8);
        chk(hl, 2'h3, "latched");
        chk(irq, 1'b0, "irq masked");
        wr(PFT_OFF_INT_MASK, 32'h2);
        wait_n(3);
        chk(irq, 1'b1, "irq raised");
        rd(PFT_OFF_INT_STATUS, 32'h2, "latch status");
        src <= 11'h10;
        wait_n(4);
        wr(PFT_OFF_FAULT_STATE, 32'h1);
        wait_n(3);
        chk(hl, 2'h3, "clear refused");
        src <= 11'h0;
        wait_n(4);
        wr(PFT_OFF_FAULT_STATE, 32'h1);
        wait_n(3);
        chk(^hl, 1'b1, "cleared");
        wr(PFT_OFF_INT_STATUS, 32'h2);
        wait_n(3);
        chk(irq, 1'b0, "irq cleared");
        for (int m = 2; m < 4; m++) begin
            wr(PFT_OFF_FAULT_LIMIT, 32'(64 + m));
            src <= 11'h10;
            wait_n(8);
            chk(^hl, 1'b1, "mode off");
            src <= 11'h0;
        end
        $display("t_modes done");
    endtask : t_modes
    // Zero first on purpose; later values stay at eight or more
    task automatic t_trig();
        wr(PFT_OFF_INT_MASK, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(PFT_OFF_INT_STATUS, 32'h7);
            wr(PFT_OFF_TRIGGER, 32'(i * 8));
            wait_n(2);
            tc = trig_cnt;
            wait_n(2 * PER);
            chk(trig_cnt - tc, (i == 0) ? 0 : 2, "trig count");
            chk(irq, i != 0, "trig irq");
        end
        wr(PFT_OFF_TRIGGER, 32'h0);
        $display("t_trig done");
    endtask : t_trig
    // Limit held active; count cycles it is hidden per two periods
    task automatic t_blank();
        logic [15:0] cfg [7] = '{16'h87F8, 16'h27F8, 16'h47F8, 16'h17F8, 16'h8BF8, 16'h07F8,
                                 16'h8408};
        logic [15:0] v;
        int          n;
        src <= 11'h400;
        wr(PFT_OFF_FAULT_LIMIT, 32'h3);
        for (int i = 0; i < 7; i++) begin
            v = cfg[i];
            wr(PFT_OFF_BLANK, {16'h0, v});
            wait_n(16);
            n = 0;
            repeat (2 * PER) begin
                @(posedge pclk);
                n += int'(limit_active === 1'b0);
            end
            chk(n, (v[10] && |v[15:12]) ? 2 * ((v[9:3] * 8 + 99) / 100) : 0, "blank");
        end
        wr(PFT_OFF_BLANK, 32'h0);
        $display("t_blank done");
    endtask : t_blank

    // Reset, then the tests in turn
    initial begin
        {psel, penable, pwrite, paddr, pwdata, src} = '0;
        {error_cnt, n_checks, cyc} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_src();
        t_modes();
        t_trig();
        t_blank();
        results();
    end
endmodule : test_pft_pwm_fault_trigger
